// ---- logic/dss_pkg.sv ----
// package of phase codes, states and timing constants for the dual slope sequencer host
package dss_pkg;
   // phase select codes as {a, b}
   localparam logic [1:0] DSS_PH_OFFSET_NULL = 2'h1;
   localparam logic [1:0] DSS_PH_INTEGRATE = 2'h2;
   localparam logic [1:0] DSS_PH_REF_RAMP = 2'h3;
   localparam logic [1:0] DSS_PH_CLEAR = 2'h0;
   // clock rate and documented times
   localparam int DSS_CLK_MHZ = 200;
   localparam int DSS_CMP_DELAY_US = 2;
   localparam int DSS_CMP_DELAY_CYC = DSS_CMP_DELAY_US * DSS_CLK_MHZ;
   localparam int DSS_INT_TIME_MS = 33;
   localparam int DSS_INT_CYC = DSS_INT_TIME_MS * DSS_CLK_MHZ * 1000;
   // sequencer states, gray coded from idle through clear; clear back to idle flips two bits
   typedef enum logic [2:0] {
      DSS_IDLE = 3'h0,
      DSS_NULL = 3'h1,
      DSS_INTEG = 3'h3,
      DSS_RAMP = 3'h2,
      DSS_CLEAR = 3'h6
   } dss_state_e;
endpackage

// ---- logic/dss_tick_counter.sv ----
// cycle counter with clear, enable and terminal flag
`timescale 1ns/1ps
`default_nettype none
module dss_tick_counter
   import dss_pkg::*;
#(
   parameter int WIDTH = 32
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic enable,
   input wire logic [WIDTH-1:0] limit,
   output logic [WIDTH-1:0] count,
   output logic at_limit
);
   // elaboration check: a one-bit counter could not tell a clear from a limit
   if (WIDTH < 2)
      $error("dss_tick_counter width too small");

   // counter saturates at the limit so it can never wrap into a small value
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else if (clear)
         count <= '0;
      else if (enable && count != limit)
         count <= count + 1'b1;
   end

   assign at_limit = (count == limit);
endmodule
`default_nettype wire

// ---- logic/dss_host_sequencer.sv ----
// host controller that steps the dual slope front end through its four phases
`timescale 1ns/1ps
`default_nettype none
module dss_host_sequencer
   import dss_pkg::*;
#(
   parameter int CW = 32,
   parameter int INT_CYCLES = DSS_INT_CYC,
   parameter int NULL_CYCLES = DSS_INT_CYC,
   parameter int RAMP_LIMIT = 2 * DSS_INT_CYC,
   parameter int CLEAR_LIMIT = DSS_INT_CYC,
   parameter int LAG_CYCLES = DSS_CMP_DELAY_CYC
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic zero_cross_compare_out,
   output logic phase_a,
   output logic phase_b,
   output logic busy,
   output logic result_valid,
   output logic result_sign,
   output logic [CW-1:0] result_count,
   output logic result_overrange
);
   // elaboration checks on the counts the shared counter must hold
   if (INT_CYCLES < 2 || NULL_CYCLES < 2 || CLEAR_LIMIT < 2)
      $error("dss_host_sequencer phase counts too small");
   // shift only taken below 32 bits so the bound never overflows an int
   if (CW < 2 || RAMP_LIMIT <= LAG_CYCLES || (CW < 32 && RAMP_LIMIT >= (1 << (CW - 1))))
      $error("dss_host_sequencer ramp limit does not fit");

   logic rst_meta_reg;
   logic rst_n_reg;
   dss_state_e state_reg;
   logic [1:0] phase_next;
   logic cnt_clear;
   logic cnt_at_limit;
   logic [CW-1:0] cnt_value;
   logic [CW-1:0] cnt_limit;
   logic cmp_prev_reg;
   logic cmp_fall;

   // reset release through two flip-flops
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // limit of the shared counter depends on the phase in progress
   always_comb
   begin
      unique case (state_reg)
         DSS_NULL: cnt_limit = CW'(NULL_CYCLES - 1);
         DSS_INTEG: cnt_limit = CW'(INT_CYCLES - 1);
         DSS_RAMP: cnt_limit = CW'(RAMP_LIMIT);
         DSS_CLEAR: cnt_limit = CW'(CLEAR_LIMIT);
         default: cnt_limit = '0;
      endcase
   end

   dss_tick_counter #(
      .WIDTH(CW)
   ) u_count (
      .clock(clock),
      .rst_n(rst_n_reg),
      .clear(cnt_clear),
      .enable(state_reg != DSS_IDLE),
      .limit(cnt_limit),
      .count(cnt_value),
      .at_limit(cnt_at_limit)
   );

   // comparator input is taken as synchronous; one stage kept for edge detection
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         cmp_prev_reg <= 1'b1;
      else
         cmp_prev_reg <= zero_cross_compare_out;
   end

   assign cmp_fall = cmp_prev_reg && !zero_cross_compare_out;

   // phase stepping; the comparator is never looked at during null
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         state_reg <= DSS_IDLE;
      else
      begin
         unique case (state_reg)
            DSS_IDLE:
               if (start)
                  state_reg <= DSS_NULL;
            DSS_NULL:
               if (cnt_at_limit)
                  state_reg <= DSS_INTEG;
            DSS_INTEG:
               if (cnt_at_limit)
                  state_reg <= DSS_RAMP;
            DSS_RAMP:
               if (cmp_fall || cnt_at_limit)
                  state_reg <= DSS_CLEAR;
            DSS_CLEAR:
               if (zero_cross_compare_out || cnt_at_limit)
                  state_reg <= DSS_IDLE;
            default:
               state_reg <= DSS_IDLE;
         endcase
      end
   end

   // counter restarts on every phase change
   assign cnt_clear = (state_reg == DSS_IDLE)
      || (state_reg == DSS_NULL && cnt_at_limit)
      || (state_reg == DSS_INTEG && cnt_at_limit)
      || (state_reg == DSS_RAMP && (cmp_fall || cnt_at_limit));

   // a/b chosen from the next state so pins change with the state itself
   always_comb
   begin
      phase_next = {phase_a, phase_b};
      unique case (state_reg)
         DSS_IDLE: phase_next = DSS_PH_OFFSET_NULL;
         DSS_NULL: phase_next = cnt_at_limit ? DSS_PH_INTEGRATE : DSS_PH_OFFSET_NULL;
         DSS_INTEG: phase_next = cnt_at_limit ? DSS_PH_REF_RAMP : DSS_PH_INTEGRATE;
         DSS_RAMP: phase_next = (cmp_fall || cnt_at_limit) ? DSS_PH_CLEAR : DSS_PH_REF_RAMP;
         DSS_CLEAR: phase_next = (zero_cross_compare_out || cnt_at_limit)
            ? DSS_PH_OFFSET_NULL : DSS_PH_CLEAR;
         default: phase_next = DSS_PH_OFFSET_NULL;
      endcase
   end

   // pins driven from flip-flops: the device latches nothing, so glitches would act at once
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         phase_a <= 1'b0;
         phase_b <= 1'b1;
      end
      else
      begin
         phase_a <= phase_next[1];
         phase_b <= phase_next[0];
      end
   end

   // busy follows the state after this edge, from a flop so it moves together with a/b
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         busy <= 1'b0;
      else if (state_reg == DSS_IDLE)
         busy <= start;
      else if (state_reg == DSS_CLEAR)
         busy <= !(zero_cross_compare_out || cnt_at_limit);
      else
         busy <= state_reg inside {DSS_NULL, DSS_INTEG, DSS_RAMP};
   end

   // sign sampled on the last integrate cycle, when the integrator swing is largest
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         result_sign <= 1'b0;
      else if (state_reg == DSS_INTEG && cnt_at_limit)
         result_sign <= ~zero_cross_compare_out;
   end

   // result: ramp length minus comparator lag, or the unreduced ramp count on overrange; the device handles reference polarity
   always_ff @(posedge clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         result_valid <= 1'b0;
         result_count <= '0;
         result_overrange <= 1'b0;
      end
      else
      begin
         result_valid <= state_reg == DSS_RAMP && (cmp_fall || cnt_at_limit);
         if (state_reg == DSS_RAMP && cmp_fall)
         begin
            result_count <= (cnt_value > CW'(LAG_CYCLES))
               ? cnt_value - CW'(LAG_CYCLES) : '0;
            result_overrange <= 1'b0;
         end
         else if (state_reg == DSS_RAMP && cnt_at_limit)
         begin
            result_count <= cnt_value;
            result_overrange <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/dss_dev_model.sv ----
// behavioural front end answering the phase selects
`timescale 1ns/1ps
`default_nettype none
module dss_dev_model
#(
   parameter int LAG = 2
)
(
   input wire logic clock,
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic positive,
   input wire logic [7:0] ramp_len,
   output logic zero_cross_compare_out
);
   logic [1:0] ab;
   logic [1:0] ab_reg = 2'h1;
   logic [7:0] cnt_reg = 8'h00;
   logic tog_reg = 1'b0;
   logic same;
   assign ab = {phase_a, phase_b};
   assign same = ab == ab_reg;
   // time in present phase; toggle stands in for an undefined level
   always_ff @(posedge clock)
   begin
      ab_reg <= ab;
      cnt_reg <= same ? cnt_reg + 8'h01 : 8'h00;
      tog_reg <= ~tog_reg;
   end
   // ramp falls after the set length plus the comparator lag
   assign zero_cross_compare_out = (ab == 2'h1) ? tog_reg :
      (ab == 2'h2) ? positive :
      (ab == 2'h3) ? (!same || cnt_reg < ramp_len + 8'(LAG)) :
      (same && cnt_reg > 8'h02);
endmodule
`default_nettype wire

// ---- dv/dss_seq_properties.sv ----
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module dss_seq_props
#(
   parameter int CW = 32
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic zero_cross_compare_out,
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic busy,
   input wire logic result_valid,
   input wire logic result_sign,
   input wire logic [CW-1:0] result_count,
   input wire logic result_overrange
);
   logic [1:0] ab;
   assign ab = {phase_a, phase_b};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_ramp_fall;
      ab == 2'h3 && $fell(zero_cross_compare_out);
   endsequence
   sequence s_enter_clear;
      $changed(ab) && ab == 2'h0;
   endsequence
   a_phase_order: assert property ($changed(ab) |-> ab == $past(ab) + 2'h1)
      else $error("phase order broken");
   a_int_hold: assert property (($changed(ab) && ab == 2'h2) |-> (ab == 2'h2) [*8])
      else $error("integration cut short");
   a_stop_on_fall: assert property (s_ramp_fall |=> ab == 2'h0 && result_valid)
      else $error("ramp not stopped");
   a_clear_exit: assert property ((ab == 2'h0 && zero_cross_compare_out) |=> ab == 2'h1)
      else $error("clear held too long");
   a_clear_bound: assert property (s_enter_clear |-> ##[1:17] ab == 2'h1)
      else $error("no return to null");
   a_valid_pulse: assert property (result_valid |=> !result_valid)
      else $error("valid too long");
   a_result_hold: assert property (!result_valid |-> $stable(result_count))
      else $error("result changed");
   a_busy_run: assert property (ab != 2'h1 |-> busy)
      else $error("busy low in a cycle");
endmodule
bind dss_host_sequencer dss_seq_props #(.CW(CW)) dss_seq_props_i (.clock, .reset_n, .start,
   .zero_cross_compare_out, .phase_a, .phase_b, .busy, .result_valid, .result_sign,
   .result_count, .result_overrange);
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the dual slope host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dss_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic positive = 1'b1;
   logic [7:0] ramp_len = 8'h0a;
   logic cmp, phase_a, phase_b, busy, result_valid, result_sign, result_overrange;
   logic [31:0] result_count;
   int n_fail = 0;
   int n_tests = 0;
   // short counts keep each conversion under a hundred cycles
   dss_host_sequencer #(.INT_CYCLES(16), .NULL_CYCLES(16), .RAMP_LIMIT(40),
      .CLEAR_LIMIT(16), .LAG_CYCLES(2)) dss_host_sequencer_i (.clock, .reset_n, .start,
      .zero_cross_compare_out(cmp), .phase_a, .phase_b, .busy, .result_valid,
      .result_sign, .result_count, .result_overrange);
   dss_dev_model dss_dev_model_i (.clock, .phase_a, .phase_b, .positive, .ramp_len,
      .zero_cross_compare_out(cmp));
   initial forever #2.5 clock = ~clock;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one conversion: start, wait for the result pulse, then for idle
   task automatic convert(input logic pos, input logic [7:0] len, input logic ovr);
      int i;
      positive = pos;
      ramp_len = len;
      start = 1'b1;
      @(posedge clock) #1;
      start = 1'b0;
      @(posedge clock) #1;
      check(busy, 1'b1);
      for (i = 0; i < 500 && result_valid !== 1'b1; i++) @(posedge clock) #1;
      check(result_valid, 1'b1);
      check(result_overrange, ovr);
      for (i = 0; i < 100 && busy === 1'b1; i++) @(posedge clock) #1;
      check(busy, 1'b0);
      check({phase_a, phase_b}, DSS_PH_OFFSET_NULL);
   endtask
   task automatic t_positive;
      convert(1'b1, 8'h0a, 1'b0);
      check(result_sign, 1'b0);
      check(result_count >= 32'h0a && result_count <= 32'h0c, 1'b1);
   endtask
   task automatic t_negative;
      convert(1'b0, 8'h14, 1'b0);
      check(result_sign, 1'b1);
      check(result_count >= 32'h14 && result_count <= 32'h16, 1'b1);
   endtask
   task automatic t_overrange;
      convert(1'b1, 8'h3c, 1'b1);
      check(result_count, 32'h28);
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clock) #1;
      check({phase_a, phase_b}, DSS_PH_OFFSET_NULL);
      t_positive();
      t_negative();
      t_overrange();
      results();
   end
   // watchdog well beyond three conversions
   initial
   begin
      #20000;
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
